// ### hdl/rcsd_pkg.sv
// shared constants and types of the remote command sync and defaults block
// assumes a single core clock; no timing figures are needed here
package rcsd_pkg;

    // command queue shape
    localparam int RCSD_QUEUE_DEPTH = 4;
    localparam logic [2:0] RCSD_QUEUE_FULL = 3'h4;

    // serial rate codes, lowest is 9600 baud, highest 115200 baud
    localparam logic [2:0] RCSD_RATE_CODE_LOWEST = 3'h0;
    localparam logic [2:0] RCSD_RATE_CODE_HIGHEST = 3'h4;

    // reply value of a finished completion query
    localparam logic [7:0] RCSD_DONE_REPLY = 8'h01;

    // apb byte offsets
    localparam logic [11:0] RCSD_STATUS_OFS = 12'h000;
    localparam logic [11:0] RCSD_RATE_OFS = 12'h004;
    localparam logic [11:0] RCSD_EVENT_OFS = 12'h008;
    localparam logic [11:0] RCSD_CONFIG_OFS = 12'h00c;

    // field positions
    localparam int RCSD_STATUS_PEND_BIT = 0;
    localparam int RCSD_STATUS_LOADED_BIT = 1;
    localparam int RCSD_STATUS_COUNT_LSB = 4;
    localparam int RCSD_EVENT_OPC_BIT = 0;

    // default token values
    localparam logic [1:0] RCSD_FIRST_RANGE = 2'h0;
    localparam logic RCSD_ISOLATION_GROUND = 1'h0;
    localparam logic RCSD_TWO_TERMINAL_SENSE = 1'h0;
    localparam logic RCSD_OUTPUT_OFF = 1'h0;
    localparam logic RCSD_SINGLE_DIRECTION = 1'h0;
    localparam logic RCSD_CYCLE_ONCE = 1'h0;
    localparam logic RCSD_DISPLAY_ON = 1'h1;
    localparam logic [1:0] RCSD_ARM_IDLE = 2'h0;
    localparam logic RCSD_CLICK_ON = 1'h1;
    localparam logic RCSD_ALARM_ON = 1'h1;
    // levels in microvolts, step time in milliseconds
    localparam logic [31:0] RCSD_LEVEL_ZERO = 32'h00000000;
    localparam logic [31:0] RCSD_SCAN_END_ONE = 32'h000f4240;
    localparam logic [31:0] RCSD_STEP_TIME_ONE = 32'h000003e8;

    typedef enum logic [2:0] {
        RCSD_OP_NONE,
        RCSD_OP_OPC_SET,
        RCSD_OP_OPC_QUERY,
        RCSD_OP_CANCEL,
        RCSD_OP_RATE_SET,
        RCSD_OP_RATE_QUERY,
        RCSD_OP_RESET
    } rcsd_op_type;

    typedef struct packed {
        rcsd_op_type op;
        logic [7:0] arg;
    } rcsd_cmd_type;

    typedef struct packed {
        logic [1:0] output_range;
        logic isolation_select;
        logic sense_wiring;
        logic output_switch;
        logic [31:0] output_level;
        logic [1:0] scan_range;
        logic [31:0] scan_begin_level;
        logic [31:0] scan_end_level;
        logic [31:0] scan_step_time;
        logic scan_shape;
        logic scan_cycle_mode;
        logic scan_display;
        logic [1:0] scan_arm_state;
        logic key_click;
        logic audible_alarm;
    } rcsd_settings_type;

    localparam rcsd_settings_type RCSD_DEFAULTS = '{
        output_range: RCSD_FIRST_RANGE,
        isolation_select: RCSD_ISOLATION_GROUND,
        sense_wiring: RCSD_TWO_TERMINAL_SENSE,
        output_switch: RCSD_OUTPUT_OFF,
        output_level: RCSD_LEVEL_ZERO,
        scan_range: RCSD_FIRST_RANGE,
        scan_begin_level: RCSD_LEVEL_ZERO,
        scan_end_level: RCSD_SCAN_END_ONE,
        scan_step_time: RCSD_STEP_TIME_ONE,
        scan_shape: RCSD_SINGLE_DIRECTION,
        scan_cycle_mode: RCSD_CYCLE_ONCE,
        scan_display: RCSD_DISPLAY_ON,
        scan_arm_state: RCSD_ARM_IDLE,
        key_click: RCSD_CLICK_ON,
        audible_alarm: RCSD_ALARM_ON
    };

endpackage : rcsd_pkg

// ### hdl/rcsd_core.sv
// command sync, serial rate and defaults logic of the remote interpreter
// assumes decoded commands, scan and panel events from same-clock logic,
// a non-volatile store answering nv_rate combinationally, and an apb master
//
// Notes on behaviour
// - a waiting completion query can be released by cancel-completion
// - completion set does not stall later commands
// - query during a running scan replies 1 only after scan ends
// - query during an endlessly repeating scan never replies by itself
// - cancel-completion clears the pending state at once
// - cancel-completion bypasses the input queue
// - after a cancel the waiting query still replies 1
// - rate command takes codes 0 to 4; rate query returns the code
// - rate command touches only the serial connector port
// - the serial rate is kept in non-volatile storage
// - a new rate is applied at once on execution
// - reset loads the documented default configuration
// - remote reset leaves the serial rate unchanged
// - power-on panel reset loads defaults and forces rate 9600
// - completion set raises the completion bit after earlier commands
// - completion query runs only after all earlier commands are done
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns

module rcsd_core
    import rcsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire rcsd_cmd_type cmd,
    output logic cmd_ready,
    output logic reply_valid,
    output logic [7:0] reply_data,
    input wire logic scan_running,
    input wire logic scan_repeat,
    input wire logic scan_done,
    input wire logic panel_cancel,
    input wire logic panel_por,
    input wire logic [2:0] nv_rate,
    output logic nv_write,
    output logic [2:0] nv_wdata,
    output logic [2:0] serial_rate_code,
    output rcsd_settings_type settings,
    output logic defaults_load,
    output logic opc_event,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // true for the five legal rate codes
    function automatic logic rate_ok(input logic [7:0] code);
        return code <= {5'h00, RCSD_RATE_CODE_HIGHEST};
    endfunction : rate_ok

    // true for the four mapped register words
    function automatic logic addr_ok(input logic [11:0] a);
        return a == RCSD_STATUS_OFS || a == RCSD_RATE_OFS ||
            a == RCSD_EVENT_OFS || a == RCSD_CONFIG_OFS;
    endfunction : addr_ok

    // queue state
    rcsd_cmd_type queue_mem [RCSD_QUEUE_DEPTH];
    logic [1:0] wr_ptr_reg, wr_ptr_next;
    logic [1:0] rd_ptr_reg, rd_ptr_next;
    logic [2:0] count_reg, count_next;
    // control state
    logic pend_reg, pend_next;
    logic loaded_reg, loaded_next;
    logic opc_reg, opc_next;
    logic [2:0] rate_reg, rate_next;
    logic nv_write_reg, nv_write_next;
    logic reply_valid_reg, reply_valid_next;
    logic [7:0] reply_data_reg, reply_data_next;
    logic defaults_reg, defaults_next;
    rcsd_settings_type settings_reg, settings_next;
    // apb state
    logic [31:0] prdata_reg, prdata_next;
    logic captured_reg, captured_next;
    logic err_reg, err_next;

    logic bypass, push, pop, apb_wr, apb_rate_wr, apb_event_wr;
    rcsd_cmd_type head;

    // cancel never enters the queue so it cannot sit behind a blocked query
    assign bypass = cmd_valid && cmd.op == RCSD_OP_CANCEL;
    assign push = ce && cmd_valid && !bypass && count_reg != RCSD_QUEUE_FULL;
    assign cmd_ready = ce && (bypass || count_reg != RCSD_QUEUE_FULL);
    assign head = queue_mem[rd_ptr_reg];
    // in-order issue; a waiting query holds everything behind it
    assign pop = ce && loaded_reg && count_reg != 3'h0 && !pend_reg;

    // apb access decode, one access cycle after a captured setup
    assign pready = ce && psel && penable && captured_reg;
    assign pslverr = pready && err_reg;
    assign apb_wr = pready && pwrite && !err_reg;
    assign apb_rate_wr = apb_wr && paddr == RCSD_RATE_OFS &&
        rate_ok(pwdata[7:0]);
    assign apb_event_wr = apb_wr && paddr == RCSD_EVENT_OFS;

    // queue pointers and occupancy
    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 2'h1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 2'h1 : rd_ptr_reg;
        count_next = count_reg + {2'h0, push} - {2'h0, pop};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= 2'h0;
            rd_ptr_reg <= 2'h0;
            count_reg <= 3'h0;
        end else if (ce) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // storage only, no reset needed on the words themselves
    always_ff @(posedge core_clk) begin
        if (push) begin
            queue_mem[wr_ptr_reg] <= cmd;
        end
    end

    // execution, pending flag, rate, defaults and replies
    always_comb begin
        pend_next = pend_reg;
        loaded_next = 1'b1;
        opc_next = opc_reg;
        rate_next = rate_reg;
        nv_write_next = 1'b0;
        reply_valid_next = 1'b0;
        reply_data_next = reply_data_reg;
        defaults_next = 1'b0;
        settings_next = settings_reg;
        // stored rate is fetched once, after reset has gone
        if (!loaded_reg) begin
            rate_next = rate_ok({5'h00, nv_rate}) ? nv_rate
                : RCSD_RATE_CODE_LOWEST;
        end
        // any of three events ends the wait and answers the query
        if (pend_reg && (bypass || panel_cancel ||
                (scan_done && !scan_repeat))) begin
            pend_next = 1'b0;
            reply_valid_next = 1'b1;
            reply_data_next = RCSD_DONE_REPLY;
        end
        if (pop) begin
            unique case (head.op)
                RCSD_OP_NONE: begin
                end
                RCSD_OP_OPC_SET: begin
                    // earlier commands already ran, later ones keep flowing
                    opc_next = 1'b1;
                end
                RCSD_OP_OPC_QUERY: begin
                    if (scan_running) begin
                        pend_next = 1'b1;
                    end else begin
                        reply_valid_next = 1'b1;
                        reply_data_next = RCSD_DONE_REPLY;
                    end
                end
                RCSD_OP_CANCEL: begin
                end
                RCSD_OP_RATE_SET: begin
                    // only the serial port rate; other links untouched
                    if (rate_ok(head.arg)) begin
                        rate_next = head.arg[2:0];
                        nv_write_next = 1'b1;
                    end
                end
                RCSD_OP_RATE_QUERY: begin
                    reply_valid_next = 1'b1;
                    reply_data_next = {5'h00, rate_reg};
                end
                RCSD_OP_RESET: begin
                    // rate deliberately left as it is
                    settings_next = RCSD_DEFAULTS;
                    defaults_next = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // register path for the rate behaves like the rate command
        if (apb_rate_wr) begin
            rate_next = pwdata[2:0];
            nv_write_next = 1'b1;
        end
        // write one to clear, a same-cycle set still wins
        if (apb_event_wr && pwdata[RCSD_EVENT_OPC_BIT]) begin
            opc_next = 1'b0;
        end
        if (pop && head.op == RCSD_OP_OPC_SET) begin
            opc_next = 1'b1;
        end
        // panel power-on reset overrides every same-cycle rate and settings change
        if (panel_por) begin
            settings_next = RCSD_DEFAULTS;
            defaults_next = 1'b1;
            rate_next = RCSD_RATE_CODE_LOWEST;
            nv_write_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
            loaded_reg <= 1'b0;
            opc_reg <= 1'b0;
            rate_reg <= RCSD_RATE_CODE_LOWEST;
            nv_write_reg <= 1'b0;
            reply_valid_reg <= 1'b0;
            reply_data_reg <= 8'h00;
            defaults_reg <= 1'b0;
            settings_reg <= RCSD_DEFAULTS;
        end else if (ce) begin
            pend_reg <= pend_next;
            loaded_reg <= loaded_next;
            opc_reg <= opc_next;
            rate_reg <= rate_next;
            nv_write_reg <= nv_write_next;
            reply_valid_reg <= reply_valid_next;
            reply_data_reg <= reply_data_next;
            defaults_reg <= defaults_next;
            settings_reg <= settings_next;
        end
    end

    assign reply_valid = reply_valid_reg;
    assign reply_data = reply_data_reg;
    assign nv_write = nv_write_reg;
    assign nv_wdata = rate_reg;
    assign serial_rate_code = rate_reg;
    assign settings = settings_reg;
    assign defaults_load = defaults_reg;
    assign opc_event = opc_reg;

    // read data is caught in setup so the access phase needs no wait
    always_comb begin
        prdata_next = prdata_reg;
        captured_next = captured_reg;
        err_next = err_reg;
        if (psel && !penable) begin
            captured_next = 1'b1;
            err_next = !addr_ok(paddr);
            prdata_next = 32'h00000000;
            unique case (1'b1)
                paddr == RCSD_STATUS_OFS: begin
                    prdata_next[RCSD_STATUS_PEND_BIT] = pend_reg;
                    prdata_next[RCSD_STATUS_LOADED_BIT] = loaded_reg;
                    prdata_next[RCSD_STATUS_COUNT_LSB +: 3] = count_reg;
                end
                paddr == RCSD_RATE_OFS: begin
                    prdata_next[2:0] = rate_reg;
                end
                paddr == RCSD_EVENT_OFS: begin
                    prdata_next[RCSD_EVENT_OPC_BIT] = opc_reg;
                end
                paddr == RCSD_CONFIG_OFS: begin
                    prdata_next[14:0] = {settings_reg.output_range,
                        settings_reg.isolation_select,
                        settings_reg.sense_wiring,
                        settings_reg.output_switch,
                        settings_reg.scan_range,
                        settings_reg.scan_shape,
                        settings_reg.scan_cycle_mode,
                        settings_reg.scan_display,
                        settings_reg.scan_arm_state,
                        settings_reg.key_click,
                        settings_reg.audible_alarm, 1'b0};
                end
                default: begin
                end
            endcase
        end else if (pready) begin
            captured_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_reg <= 32'h00000000;
            captured_reg <= 1'b0;
            err_reg <= 1'b0;
        end else if (ce) begin
            prdata_reg <= prdata_next;
            captured_reg <= captured_next;
            err_reg <= err_next;
        end
    end

    assign prdata = prdata_reg;

    // checks on the sequencing above
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_query_starts_wait;
        ce && pop && head.op == RCSD_OP_OPC_QUERY && scan_running;
    endsequence

    sequence s_scan_release;
        ce && pend_reg && scan_done && !scan_repeat && !panel_por;
    endsequence

    a_query_waits_scan: assert property (
        s_query_starts_wait |=> pend_reg && !reply_valid)
        else $error("query during scan did not wait");

    a_scan_end_reply: assert property (
        s_scan_release |=> reply_valid &&
            reply_data == RCSD_DONE_REPLY && !pend_reg)
        else $error("scan end did not answer the query");

    a_idle_query_reply: assert property (
        ce && pop && head.op == RCSD_OP_OPC_QUERY && !scan_running
        |=> reply_valid && reply_data == RCSD_DONE_REPLY && !pend_reg)
        else $error("idle query not answered next cycle");

    a_cancel_releases: assert property (
        ce && pend_reg && bypass |=> !pend_reg && reply_valid &&
            reply_data == RCSD_DONE_REPLY)
        else $error("cancel did not release the query");

    // the queue must not advance and nothing may answer while waiting
    a_pending_blocks: assert property (
        ce && pend_reg && !bypass && !panel_cancel && !scan_done
        |=> !reply_valid && $stable(rd_ptr_reg))
        else $error("command ran while query waits");

    a_repeat_silent: assert property (
        ce && pend_reg && scan_repeat && !bypass && !panel_cancel
        |=> pend_reg && !reply_valid)
        else $error("repeating scan released the query");

    a_cancel_bypass: assert property (
        cmd_valid && bypass |-> cmd_ready == ce && !push)
        else $error("cancel was queued or refused");

    a_opc_set_flows: assert property (
        ce && pop && head.op == RCSD_OP_OPC_SET |=> opc_event && !pend_reg)
        else $error("completion set did not raise the bit");

    a_rate_apply: assert property (
        ce && pop && head.op == RCSD_OP_RATE_SET && rate_ok(head.arg) &&
            !panel_por && !apb_rate_wr
        |=> serial_rate_code == $past(head.arg[2:0]) && nv_write)
        else $error("rate not applied at once");

    a_reset_keeps_rate: assert property (
        ce && pop && head.op == RCSD_OP_RESET && !panel_por && !apb_rate_wr
        |=> settings == RCSD_DEFAULTS && $stable(serial_rate_code) &&
            !nv_write)
        else $error("remote reset disturbed the rate");

    a_por_defaults: assert property (
        ce && panel_por |=> settings == RCSD_DEFAULTS && nv_write &&
            serial_rate_code == RCSD_RATE_CODE_LOWEST)
        else $error("panel reset did not restore defaults");

    a_rate_query: assert property (
        ce && pop && head.op == RCSD_OP_RATE_QUERY
        |=> reply_valid && reply_data == {5'h00, $past(rate_reg)})
        else $error("rate query returned wrong code");

endmodule : rcsd_core

// ### test/rcsd_host.sv
// host model: queues decoded commands and offers them one at a time
// assumes the interpreter takes a command at an edge with valid and ready
`timescale 1ns/1ns

module rcsd_host
    import rcsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output rcsd_cmd_type cmd
);
    rcsd_cmd_type q[$];
    logic gap;
    logic [2:0] link_rate;

    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        link_rate = 3'h0;
    end

    task automatic send(input rcsd_op_type op, input logic [7:0] arg);
        q.push_back('{op: op, arg: arg});
    endtask : send

    // hold until taken; a slow host idles a cycle between commands
    always @(posedge core_clk) begin
        gap = 1'b0;
        if (cmd_valid && cmd_ready) begin
            void'(q.pop_front());
            gap = slow;
        end
        if (!rst && !gap && q.size() > 0) begin
            cmd_valid <= 1'b1;
            cmd <= q[0];
        end else begin
            cmd_valid <= 1'b0;
            cmd <= rcsd_cmd_type'(~cmd); // stale lines must not look valid
        end
    end

    // follow a rate change on our own port to keep talking
    always @(posedge core_clk) begin
        if (cmd_valid && cmd_ready && cmd.op == RCSD_OP_RATE_SET &&
            cmd.arg <= 8'h04) begin
            link_rate <= cmd.arg[2:0];
        end
    end
endmodule : rcsd_host

// ### test/test_remote_cmd_sync_and_defaults.sv
// self-checking bench of the remote command sync and defaults block
// assumes the host model rcsd_host and an apb master driven from here
`timescale 1ns/1ns

module test_remote_cmd_sync_and_defaults
    import rcsd_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
    logic cmd_valid, cmd_ready, reply_valid, nv_write, defaults_load;
    logic opc_event, psel, penable, pwrite, pready, pslverr, err;
    logic scan_running, scan_repeat, scan_done, panel_cancel, panel_por;
    logic [7:0] reply_data;
    logic [2:0] nv_rate, nv_wdata, serial_rate_code, nv_last, code;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rcsd_cmd_type cmd;
    rcsd_settings_type settings;
    logic [7:0] exp_q[$];
    int failures = 0, n_tests = 0, n_replies = 0, n_loads = 0, base;

    always #5 core_clk = ~core_clk;

    rcsd_core i_rcsd_core (.core_clk(core_clk), .rst(rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .reply_valid(reply_valid), .reply_data(reply_data),
        .scan_running(scan_running), .scan_repeat(scan_repeat),
        .scan_done(scan_done), .panel_cancel(panel_cancel),
        .panel_por(panel_por), .nv_rate(nv_rate), .nv_write(nv_write),
        .nv_wdata(nv_wdata), .serial_rate_code(serial_rate_code),
        .settings(settings), .defaults_load(defaults_load),
        .opc_event(opc_event), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    rcsd_host i_rcsd_host (.core_clk(core_clk), .rst(rst), .slow(slow),
        .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd));

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic give_up(input int n);
        if (n >= 300) begin
            failures++;
            $display("Error at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask : give_up

    task automatic wait_replies(input int target);
        int n;
        n = 0;
        while (n_replies < target && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        give_up(n);
    endtask : wait_replies

    // one apb transfer; idles an edge after so psel is never re-set at once
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        give_up(n);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // replies are scored against the oldest note; store writes are tracked
    // sampled mid-cycle so one-cycle pulses are read settled, race free
    always @(negedge core_clk) begin
        if (!rst && reply_valid === 1'b1) begin
            n_replies++;
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else check(reply_data, exp_q.pop_front());
        end
        if (nv_write === 1'b1) nv_last = nv_wdata;
        if (defaults_load === 1'b1) n_loads++;
    end

    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end

    initial begin
        {scan_running, scan_repeat, scan_done} = 3'h0;
        {panel_cancel, panel_por, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        nv_rate = 3'h3;
        void'($urandom(32'hfb9f778d));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(settings === RCSD_DEFAULTS, 1'b1);
        check(serial_rate_code, 3'h3);
        $display("test power-up done");
        // every rate code, a random one, then an illegal code
        for (int i = 0; i < 7; i++) begin
            if (i < 6) code = (i < 5) ? 3'(i) : 3'($urandom_range(4, 0));
            i_rcsd_host.send(RCSD_OP_RATE_SET, (i < 6) ? {5'h00, code} : 8'h07);
            i_rcsd_host.send(RCSD_OP_RATE_QUERY, 8'h00);
            exp_q.push_back({5'h00, code});
            wait_replies(n_replies + 1);
            check(serial_rate_code, code);
            check(nv_last, code);
        end
        check(i_rcsd_host.link_rate, code);
        $display("test rate codes done");
        // query waits for the scan, later command held behind it
        scan_running <= 1'b1;
        base = n_replies;
        exp_q.push_back(RCSD_DONE_REPLY);
        exp_q.push_back({5'h00, code});
        i_rcsd_host.send(RCSD_OP_OPC_QUERY, 8'h00);
        i_rcsd_host.send(RCSD_OP_RATE_QUERY, 8'h00);
        repeat (30) @(posedge core_clk);
        check(n_replies, base);
        apb(1'b0, RCSD_STATUS_OFS, 32'h0, rd, err);
        check(rd[RCSD_STATUS_PEND_BIT], 1'b1);
        scan_done <= 1'b1;
        @(posedge core_clk);
        scan_done <= 1'b0;
        wait_replies(base + 2);
        $display("test query during scan done");
        // endless scan: queue fills, cancel goes round it
        scan_repeat <= 1'b1;
        base = n_replies;
        i_rcsd_host.send(RCSD_OP_OPC_QUERY, 8'h00);
        repeat (4) i_rcsd_host.send(RCSD_OP_RATE_QUERY, 8'h00);
        repeat (30) @(posedge core_clk);
        scan_done <= 1'b1;
        @(posedge core_clk);
        scan_done <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(n_replies, base);
        apb(1'b0, RCSD_STATUS_OFS, 32'h0, rd, err);
        check(rd[RCSD_STATUS_COUNT_LSB +: 3], RCSD_QUEUE_FULL);
        exp_q.push_back(RCSD_DONE_REPLY);
        repeat (4) exp_q.push_back({5'h00, code});
        i_rcsd_host.send(RCSD_OP_CANCEL, 8'h00);
        wait_replies(base + 5);
        apb(1'b0, RCSD_STATUS_OFS, 32'h0, rd, err);
        check(rd[RCSD_STATUS_PEND_BIT], 1'b0);
        // a panel cancel releases the waiting query too
        exp_q.push_back(RCSD_DONE_REPLY);
        i_rcsd_host.send(RCSD_OP_OPC_QUERY, 8'h00);
        repeat (10) @(posedge core_clk);
        panel_cancel <= 1'b1;
        @(posedge core_clk);
        panel_cancel <= 1'b0;
        wait_replies(base + 6);
        scan_repeat <= 1'b0;
        $display("test cancel done");
        // completion set during a scan, slow host, does not block
        slow <= 1'b1;
        i_rcsd_host.send(RCSD_OP_OPC_SET, 8'h00);
        i_rcsd_host.send(RCSD_OP_RATE_QUERY, 8'h00);
        exp_q.push_back({5'h00, code});
        wait_replies(n_replies + 1);
        check(opc_event, 1'b1);
        apb(1'b1, RCSD_EVENT_OFS, 32'h1, rd, err);
        check(opc_event, 1'b0);
        scan_running <= 1'b0;
        $display("test completion set done");
        // rate over apb, then an unmapped word
        code = 3'($urandom_range(4, 0));
        apb(1'b1, RCSD_RATE_OFS, {29'h0, code}, rd, err);
        check(serial_rate_code, code);
        check(nv_last, code);
        apb(1'b0, RCSD_RATE_OFS, 32'h0, rd, err);
        check(rd, {29'h0, code});
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test apb done");
        // power cycle in mid-run: the stored rate comes back
        nv_rate <= nv_last;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(serial_rate_code, code);
        $display("test power cycle done");
        // remote reset keeps the rate, panel reset forces the lowest
        base = n_loads;
        i_rcsd_host.send(RCSD_OP_RESET, 8'h00);
        repeat (5) @(posedge core_clk);
        check(n_loads, base + 1);
        check(serial_rate_code, code);
        panel_por <= 1'b1;
        @(posedge core_clk);
        panel_por <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(serial_rate_code, RCSD_RATE_CODE_LOWEST);
        check(nv_last, RCSD_RATE_CODE_LOWEST);
        check(settings === RCSD_DEFAULTS, 1'b1);
        check(n_loads, base + 2);
        $display("test resets done");
        // a low clock enable holds a command back until it rises again
        ce <= 1'b0;
        base = n_replies;
        exp_q.push_back({5'h00, RCSD_RATE_CODE_LOWEST});
        i_rcsd_host.send(RCSD_OP_RATE_QUERY, 8'h00);
        repeat (10) @(posedge core_clk);
        check(n_replies, base);
        check(cmd_ready, 1'b0);
        ce <= 1'b1;
        wait_replies(base + 1);
        $display("test clock enable done");
        report_and_stop();
    end
endmodule : test_remote_cmd_sync_and_defaults
